// File: bench/iohp_host_model.sv
// isa host model issuing one i/o cycle per call of cyc
// assumes cyc is called at a falling clock edge
`timescale 1ns/10ps
module iohp_host_model (
    // clock and read answer
    input  wire logic        clk_in,
    input  wire logic [15:0] rd_data_in,
    input  wire logic        oe_in,
    // isa pins
    output logic      [15:0] sa_out = 16'h0,
    output logic             aen_out = 1'b1,
    output logic             ior_n_out = 1'b1,
    output logic             iow_n_out = 1'b1,
    output logic      [15:0] sd_out = 16'h0,
    // captured read
    output logic             rd_seen_out = 1'b0,
    output logic      [15:0] rd_val_out = 16'h0
);
    logic [15:0] base = 16'h0300;
    // strobe low 6 clocks, high 3: the port syncs both edges through two flops
    task cyc(input [3:0] ofs, input wr, input [15:0] d, input off);
        sa_out = base + {12'h0, ofs};
        aen_out = off;
        if (wr) sd_out = d;
        ior_n_out = wr;
        iow_n_out = !wr;
        repeat (5) @(negedge clk_in);
        @(posedge clk_in);
        rd_val_out <= rd_data_in;
        rd_seen_out <= !wr && oe_in;
        @(negedge clk_in);
        ior_n_out = 1'b1;
        iow_n_out = 1'b1;
        aen_out = 1'b1;
        sd_out = ~sd_out; // released bus shows no stale word
        @(posedge clk_in);
        rd_seen_out <= 1'b0;
        repeat (3) @(negedge clk_in);
    endtask
endmodule

// File: bench/iohp_port_properties.sv
// assertions on the host port pins and its internal side
// assumes the host holds address and data steady for a whole strobe
`timescale 1ns/10ps
module iohp_port_properties #(parameter BUF_W = 16) (
    input wire logic             clock_in,
    input wire logic             rst_n_in,
    input wire logic [15:0]      sa_in,
    input wire logic             aen_in,
    input wire logic             ior_n_in,
    input wire logic             iow_n_in,
    input wire logic             sd_oe_out,
    input wire logic             intrq_out,
    input wire logic [11:0]      reg_addr_out,
    input wire logic             reg_wr_out,
    input wire logic             reg_rd_out,
    input wire logic             irq_enable_in,
    input wire logic             queue_valid_in,
    input wire logic             queue_pop_out,
    input wire logic [BUF_W-1:0] tx_data_out,
    input wire logic             tx_valid_out,
    input wire logic             tx_ready_in
);
    // cycles since each strobe or aen was last seen; saturates so it never wraps
    logic [2:0] rd_age_r, wr_age_r, aen_age_r;
    function automatic [2:0] age_nxt(input act, input [2:0] a);
        age_nxt = act ? 3'h0 : a + {2'h0, a != 3'h7};
    endfunction
    always @(posedge clock_in) begin
        rd_age_r  <= !rst_n_in ? 3'h7 : age_nxt(!ior_n_in, rd_age_r);
        wr_age_r  <= !rst_n_in ? 3'h7 : age_nxt(!iow_n_in, wr_age_r);
        aen_age_r <= !rst_n_in ? 3'h0 : age_nxt(aen_in, aen_age_r);
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    a_oe_after_read:
        assert property (sd_oe_out |-> rd_age_r < 3'h5) else $error("bus driven without read");
    a_rd_needs_aen:
        assert property (reg_rd_out |-> rd_age_r < 3'h2 && aen_age_r > 3'h0)
        else $error("register read outside a valid cycle");
    a_wr_needs_aen:
        assert property (reg_wr_out |-> wr_age_r < 3'h2 && aen_age_r > 3'h0)
        else $error("register write outside a valid cycle");
    a_cmd_alias:
        assert property (reg_wr_out && sa_in[3:0] == 4'h4 |-> reg_addr_out == 12'h144)
        else $error("command port not aliased");
    a_len_alias:
        assert property (reg_wr_out && sa_in[3:0] == 4'h6 |-> reg_addr_out == 12'h146)
        else $error("length port not aliased");
    a_pop_on_read:
        assert property (queue_pop_out |-> sa_in[3:0] == 4'h8 && rd_age_r < 3'h4)
        else $error("queue advanced without a queue read");
    a_irq_gated:
        assert property (!irq_enable_in |-> !intrq_out) else $error("interrupt while disabled");
    a_irq_queue:
        assert property (irq_enable_in && queue_valid_in |-> intrq_out)
        else $error("pending event without interrupt");
    a_tx_held:
        assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
        else $error("stalled word dropped or changed");
endmodule

// File: bench/isa_io_mode_host_port_tb_top.sv
// testbench for the i/o host port: host model in front, register space behind
// assumes a 10 MHz clock and the two-flop strobe sync of the port
`timescale 1ns/10ps
module isa_io_mode_host_port_tb_top;
    logic        clock_in = 1'b0, rst_n_in = 1'b0, base_load_in = 1'b0, stall = 1'b1;
    logic        bid_len_bad_in = 1'b0, tx_space_in = 1'b0, rdy_ie_in = 1'b1;
    logic        irq_enable_in = 1'b0, queue_valid_in = 1'b0, rx_valid_in = 1'b0;
    logic        tx_ready_in = 1'b0, rd_seen;
    logic [15:0] base_value_in = 16'h0340, queue_head_in = 16'h0, rd_val;
    logic [15:0] rx_status_in = 16'h0, rx_length_in = 16'h0, v [0:2], rx_w [0:3];
    logic [15:0] regs [0:2047];
    logic [1:0]  rx_i = 2'h0;
    logic [31:0] xm, exp_q [$];
    logic [15:0] tx_q [$];
    integer      seed = 66, rnd, i, errors = 0, total_checks = 0;
    wire  [15:0] sa_in, sd_in, sd_out, tx_data_out, reg_wdata_out;
    wire  [11:0] reg_addr_out;
    wire         aen_in, ior_n_in, iow_n_in, sd_oe_out, intrq_out, reg_wr_out, reg_rd_out;
    wire         queue_pop_out, rx_ready_out, tx_valid_out;
    wire  [15:0] reg_rdata_in = regs[reg_addr_out[11:1]];
    wire  [15:0] rx_data_in = rx_w[rx_i];
    iohp_port dut (.clock_in, .rst_n_in, .sa_in, .aen_in, .ior_n_in, .iow_n_in, .sd_in,
        .sd_out, .sd_oe_out, .intrq_out, .base_load_in, .base_value_in, .reg_addr_out,
        .reg_wdata_out, .reg_wr_out, .reg_rd_out, .reg_rdata_in, .bid_len_bad_in, .tx_space_in,
        .rdy_ie_in, .irq_enable_in, .queue_head_in, .queue_valid_in, .queue_pop_out,
        .rx_status_in, .rx_length_in, .rx_data_in, .rx_valid_in, .rx_ready_out, .tx_data_out,
        .tx_valid_out, .tx_ready_in);
    iohp_host_model host (.clk_in(clock_in), .rd_data_in(sd_out), .oe_in(sd_oe_out),
        .sa_out(sa_in), .aen_out(aen_in), .ior_n_out(ior_n_in), .iow_n_out(iow_n_in),
        .sd_out(sd_in), .rd_seen_out(rd_seen), .rd_val_out(rd_val));
    initial forever #50 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        if (reg_wr_out) regs[reg_addr_out[11:1]] <= reg_wdata_out;
        if (rx_ready_out) rx_i <= rx_i + 2'h1;
    end
    always @(negedge clock_in) begin
        rnd = $random(seed);
        tx_ready_in <= !stall && rnd[0];
    end
    task check(input string n, input [15:0] s, input [15:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input [3:0] o, input [15:0] d);
        host.cyc(o, 1'b1, d, 1'b0);
    endtask
    task rd(input [3:0] o, input [15:0] m, input [15:0] e);
        exp_q.push_back({m, e});
        host.cyc(o, 1'b0, 16'h0, 1'b0);
    endtask
    // oldest note against each read result and each word leaving the buffer
    always @(posedge clock_in) begin
        if (rd_seen) begin
            xm = exp_q.size() ? exp_q.pop_front() : 32'h0000dead;
            check("read", rd_val & xm[31:16], xm[15:0]);
        end
        if (tx_valid_out && tx_ready_in) check("tx word", tx_data_out, tx_q.pop_front());
    end
    task end_sim;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #600000;
        errors++;
        end_sim;
    end
    initial begin
        for (i = 0; i < 2048; i++) regs[i] = 16'h0;
        for (i = 0; i < 4; i++) rx_w[i] = $random(seed);
        repeat (2) @(negedge clock_in);
        rst_n_in = 1'b1;
        repeat (3) @(negedge clock_in);
        rd(4'ha, 16'hffff, 16'h3000);
        wr(4'ha, 16'hffff);
        rd(4'ha, 16'hffff, 16'hbfff);
        wr(4'ha, 16'h8040);
        for (i = 0; i < 3; i++) begin
            v[i] = $random(seed);
            wr(4'hc, v[i]);
        end
        rd(4'ha, 16'hffff, 16'hb046);
        wr(4'ha, 16'h0040);
        rd(4'hc, 16'hffff, v[0]);
        rd(4'hc, 16'hffff, v[0]);
        rd(4'he, 16'hffff, v[1]);
        wr(4'ha, 16'h8040);
        for (i = 0; i < 3; i++) rd(4'hc, 16'hffff, v[i]);
        bid_len_bad_in = 1'b1;
        wr(4'h4, 16'h00c0);
        wr(4'h6, 16'h0040);
        wr(4'ha, 16'h0138);
        rd(4'hc, 16'h0180, 16'h0080);
        rd(4'h4, 16'hffff, 16'h0000);
        bid_len_bad_in = 1'b0;
        wr(4'h4, 16'h00c0);
        wr(4'h6, 16'h0040);
        rd(4'hc, 16'h0100, 16'h0000);
        tx_space_in = 1'b1;
        irq_enable_in = 1'b1;
        queue_head_in = 16'h0504;
        queue_valid_in = 1'b1;
        rd(4'hc, 16'h0100, 16'h0100);
        rd(4'h8, 16'hffff, 16'h010c);
        rd(4'h8, 16'hffff, 16'h0504);
        queue_valid_in = 1'b0;
        queue_head_in = 16'h0;
        rd(4'h8, 16'hffff, 16'h0000);
        // three words into a stalled two-entry buffer: the last is refused
        for (i = 0; i < 3; i++) begin
            v[i] = $random(seed);
            wr(4'h0, v[i]);
        end
        tx_q.push_back(v[0]);
        tx_q.push_back(v[1]);
        stall = 1'b0;
        repeat (20) @(negedge clock_in);
        tx_q.push_back(v[2]);
        wr(4'h2, v[2]);
        rx_status_in = $random(seed);
        rx_length_in = $random(seed);
        rx_valid_in = 1'b1;
        rd(4'h0, 16'hffff, rx_status_in);
        rd(4'h0, 16'hffff, rx_length_in);
        rd(4'h0, 16'hffff, rx_w[0]);
        rd(4'h0, 16'hffff, rx_w[1]);
        host.cyc(4'ha, 1'b1, 16'h0123, 1'b1);
        base_load_in = 1'b1;
        @(negedge clock_in);
        base_load_in = 1'b0;
        host.base = 16'h0340;
        rd(4'ha, 16'hffff, 16'h3138);
        repeat (10) @(negedge clock_in);
        check("pending", 16'(exp_q.size() + tx_q.size()), 16'h0);
        end_sim;
    end
endmodule
bind iohp_port iohp_port_properties #(.BUF_W(BUF_W)) chk (.clock_in, .rst_n_in, .sa_in,
    .aen_in, .ior_n_in, .iow_n_in, .sd_oe_out, .intrq_out, .reg_addr_out, .reg_wr_out,
    .reg_rd_out, .irq_enable_in, .queue_valid_in, .queue_pop_out, .tx_data_out, .tx_valid_out,
    .tx_ready_in);

// File: core/iohp_defs.vh
// constants for the isa i/o mode host port
// assumes inclusion by the port module only
`ifndef IOHP_DEFS_VH
`define IOHP_DEFS_VH
`define IOHP_BASE_RESET      16'h0300
`define IOHP_OFS_FRAME_LO    4'h0
`define IOHP_OFS_FRAME_HI    4'h2
`define IOHP_OFS_TX_CMD      4'h4
`define IOHP_OFS_TX_LEN      4'h6
`define IOHP_OFS_QUEUE       4'h8
`define IOHP_OFS_POINTER     4'ha
`define IOHP_OFS_DATA_LO     4'hc
`define IOHP_OFS_DATA_HI     4'he
`define IOHP_ADDR_TX_CMD     12'h144
`define IOHP_ADDR_TX_LEN     12'h146
`define IOHP_ADDR_QUEUE      12'h120
`define IOHP_ADDR_BUS_STATUS 12'h138
`define IOHP_PTR_FIXED       3'h3
`define IOHP_PTR_AUTO_BIT    15
`define IOHP_PTR_ADDR_MSB    11
`define IOHP_BS_RDY_NOW_BIT  8
`define IOHP_BS_BID_ERR_BIT  7
`define IOHP_BUF_EVENT_REG   6'h0c
`define IOHP_RDY_EVENT_BIT   8
`define IOHP_RDY_IE_BIT      8
`define IOHP_QUEUE_EMPTY     16'h0000
`define IOHP_WORD_STEP       12'h002
`define IOHP_RX_STATUS       2'h0
`define IOHP_RX_LENGTH       2'h1
`define IOHP_RX_FRAME        2'h2
`endif

// File: core/iohp_port.v
// isa i/o space host port: 16-byte window decode, indirect register access,
// transmit bid and receive readout. assumes isa strobes are asynchronous and
// are synchronised here; the internal register space answers combinationally.
`timescale 1ns/10ps
`include "iohp_defs.vh"

// Contract
// - eight 16-bit ports fill sixteen byte locations; always enabled.
// - window base resets to 300h, relocatable to any xxx0h address.
// - frame data ports at 0 and 2; low word at port 0.
// - transmit command written at 4 aliases internal location 0144h.
// - frame length written at 6 aliases internal location 0146h.
// - port 8 reads head of event status queue, location 0120h.
// - pointer low 12 bits address the indirect register target.
// - pointer bits c..e read 011b, written values ignored.
// - pointer bit f set makes pointer advance one word per access.
// - data port c reaches pointed register; e holds upper word.
// - respond only with aen low, address in window, strobe low.
// - ready event set when space frees; interrupt if enabled.
// - invalid bid length sets bid error bit 7 of bus status.
// - repeated writes to port 0 go into buffer memory.
// - received frame raises enabled interrupt; host reads queue.
// - receive reads return status, length, then frame words.
// - queue word: register number low six bits, contents above; read advances.
module iohp_port #(
    parameter BUF_W = 16
) (
    // clock and reset
    input  wire        clock_in,
    input  wire        rst_n_in,
    // isa pins
    input  wire [15:0] sa_in,
    input  wire        aen_in,
    input  wire        ior_n_in,
    input  wire        iow_n_in,
    input  wire [15:0] sd_in,
    output reg  [15:0] sd_out,
    output wire        sd_oe_out,
    output wire        intrq_out,
    // setup base load
    input  wire        base_load_in,
    input  wire [15:0] base_value_in,
    // internal register space
    output reg  [11:0] reg_addr_out,
    output reg  [15:0] reg_wdata_out,
    output reg         reg_wr_out,
    output reg         reg_rd_out,
    input  wire [15:0] reg_rdata_in,
    // transmit bid and status
    input  wire        bid_len_bad_in,
    input  wire        tx_space_in,
    input  wire        rdy_ie_in,
    input  wire        irq_enable_in,
    // event queue
    input  wire [15:0] queue_head_in,
    input  wire        queue_valid_in,
    output reg         queue_pop_out,
    // receive stream
    input  wire [15:0] rx_status_in,
    input  wire [15:0] rx_length_in,
    input  wire [BUF_W-1:0] rx_data_in,
    input  wire        rx_valid_in,
    output wire        rx_ready_out,
    // transmit stream through two-entry buffer
    output wire [BUF_W-1:0] tx_data_out,
    output wire        tx_valid_out,
    input  wire        tx_ready_in
);
    localparam [1:0] BUF_EMPTY = 2'h0;
    localparam [1:0] BUF_ONE   = 2'h1;
    localparam [1:0] BUF_FULL  = 2'h2;

    // two-flop synchronisers; stage three only delays stage two for edges
    reg  [2:0]        ior_s_r;
    reg  [2:0]        iow_s_r;
    reg  [1:0]        aen_s_r;
    reg  [15:0]       sa_s0_r;
    reg  [15:0]       sa_s1_r;
    reg  [15:0]       sd_s0_r;
    reg  [15:0]       sd_s1_r;

    // window base, pointer and flags
    reg  [15:0]       base_r;
    reg  [15:0]       ptr_r;
    reg               bid_err_r;
    reg               rdy_event_r;
    reg               waiting_r;
    reg               rx_frame_r;
    reg  [1:0]        rx_phase_r;
    reg               rd_act_r;

    // transmit buffer
    reg  [BUF_W-1:0]  buf_d0_r;
    reg  [BUF_W-1:0]  buf_d1_r;
    reg  [1:0]        buf_cnt_r;

    // decode
    wire              in_win;
    wire              rd_start;
    wire              wr_start;
    wire              is_data_lo;
    wire              is_data_hi;
    wire              data_acc;
    wire              buf_ready;
    wire              push;
    wire              pop;
    wire [15:0]       ptr_rd;
    wire [15:0]       bus_status_word;
    wire [15:0]       ready_report_word;
    wire [BUF_W+15:0] rx_ext;

    // strobes reset to their idle high level so no false edge follows reset
    always @(posedge clock_in) begin
        if (!rst_n_in) begin
            ior_s_r <= 3'h7;
            iow_s_r <= 3'h7;
            aen_s_r <= 2'h3;
        end else begin
            ior_s_r <= {ior_s_r[1:0], ior_n_in};
            iow_s_r <= {iow_s_r[1:0], iow_n_in};
            aen_s_r <= {aen_s_r[0], aen_in};
        end
    end

    always @(posedge clock_in) begin
        if (!rst_n_in) begin
            sa_s0_r <= 16'h0000;
            sa_s1_r <= 16'h0000;
            sd_s0_r <= 16'h0000;
            sd_s1_r <= 16'h0000;
        end else begin
            sa_s0_r <= sa_in;
            sa_s1_r <= sa_s0_r;
            sd_s0_r <= sd_in;
            sd_s1_r <= sd_s0_r;
        end
    end

    // only the second stage and its delayed copy feed edge detection
    assign in_win     = !aen_s_r[1] && (sa_s1_r[15:4] == base_r[15:4]);
    assign rd_start   = in_win && !ior_s_r[1] && ior_s_r[2];
    assign wr_start   = in_win && !iow_s_r[1] && iow_s_r[2] && buf_ready;
    assign is_data_lo = sa_s1_r[3:0] == `IOHP_OFS_DATA_LO;
    assign is_data_hi = sa_s1_r[3:0] == `IOHP_OFS_DATA_HI;
    // a 32-bit access ends at the upper word, so one step per completed word
    assign data_acc   = (rd_start || wr_start) && (is_data_lo || is_data_hi);
    assign ptr_rd     = {ptr_r[`IOHP_PTR_AUTO_BIT], `IOHP_PTR_FIXED,
                         ptr_r[`IOHP_PTR_ADDR_MSB:0]};
    assign sd_oe_out  = rd_act_r && !ior_s_r[1];
    assign intrq_out  = irq_enable_in && (queue_valid_in || (rdy_event_r && rdy_ie_in));

    // internal register access, decoded per port
    always @* begin
        reg_addr_out  = ptr_r[`IOHP_PTR_ADDR_MSB:0];
        reg_wdata_out = sd_s1_r;
        reg_wr_out    = 1'b0;
        reg_rd_out    = 1'b0;
        if (is_data_hi) begin
            reg_addr_out = ptr_r[`IOHP_PTR_ADDR_MSB:0] + `IOHP_WORD_STEP;
        end
        if (sa_s1_r[3:0] == `IOHP_OFS_TX_CMD) begin
            reg_addr_out = `IOHP_ADDR_TX_CMD;
        end
        if (sa_s1_r[3:0] == `IOHP_OFS_TX_LEN) begin
            reg_addr_out = `IOHP_ADDR_TX_LEN;
        end
        if (wr_start && (is_data_lo || is_data_hi ||
            sa_s1_r[3:0] == `IOHP_OFS_TX_CMD || sa_s1_r[3:0] == `IOHP_OFS_TX_LEN)) begin
            reg_wr_out = 1'b1;
        end
        if (rd_start && (is_data_lo || is_data_hi)) begin
            reg_rd_out = 1'b1;
        end
    end

    // transmit buffer
    assign push         = wr_start && (sa_s1_r[3:0] == `IOHP_OFS_FRAME_LO ||
                                       sa_s1_r[3:0] == `IOHP_OFS_FRAME_HI);
    // a write into a full buffer is refused rather than overwriting a stalled word
    assign buf_ready    = buf_cnt_r != BUF_FULL;
    assign tx_valid_out = buf_cnt_r != BUF_EMPTY;
    assign tx_data_out  = buf_d0_r;
    assign pop          = tx_valid_out && tx_ready_in;
    assign rx_ready_out = rd_start && rx_phase_r == `IOHP_RX_FRAME &&
                          (sa_s1_r[3:0] == `IOHP_OFS_FRAME_LO ||
                           sa_s1_r[3:0] == `IOHP_OFS_FRAME_HI);
    assign rx_ext       = {16'h0000, rx_data_in};
    // ready now stays low while a bid still waits for buffer space
    assign bus_status_word   = {7'h00, !waiting_r && tx_space_in, bid_err_r,
                                reg_rdata_in[6:0]};
    assign ready_report_word = {7'h00, 1'b1, 2'h0, `IOHP_BUF_EVENT_REG};

    always @(posedge clock_in) begin
        if (!rst_n_in) begin
            buf_cnt_r <= 2'h0;
            buf_d0_r  <= {BUF_W{1'b0}};
            buf_d1_r  <= {BUF_W{1'b0}};
        end else begin
            if (pop) begin
                buf_d0_r <= (buf_cnt_r == BUF_FULL) ? buf_d1_r : sd_s1_r[BUF_W-1:0];
            end
            if (push && (buf_cnt_r == BUF_EMPTY || (pop && buf_cnt_r == BUF_ONE))) begin
                buf_d0_r <= sd_s1_r[BUF_W-1:0];
            end else if (push) begin
                buf_d1_r <= sd_s1_r[BUF_W-1:0];
            end
            if (push && !pop) begin
                buf_cnt_r <= buf_cnt_r + BUF_ONE;
            end else if (pop && !push) begin
                buf_cnt_r <= buf_cnt_r - BUF_ONE;
            end
        end
    end

    // base, pointer, status flags and read data
    always @(posedge clock_in) begin
        if (!rst_n_in) begin
            base_r        <= `IOHP_BASE_RESET;
            ptr_r         <= 16'h0000;
            bid_err_r     <= 1'b0;
            rdy_event_r   <= 1'b0;
            waiting_r     <= 1'b0;
            rx_frame_r    <= 1'b0;
            rx_phase_r    <= `IOHP_RX_STATUS;
            rd_act_r      <= 1'b0;
            sd_out        <= 16'h0000;
            queue_pop_out <= 1'b0;
        end else begin
            queue_pop_out <= 1'b0;
            if (base_load_in) begin
                base_r <= {base_value_in[15:4], 4'h0};
            end
            if (ior_s_r[1]) begin
                rd_act_r <= 1'b0;
            end
            if (wr_start && sa_s1_r[3:0] == `IOHP_OFS_POINTER) begin
                ptr_r <= {sd_s1_r[`IOHP_PTR_AUTO_BIT], 3'h0,
                          sd_s1_r[`IOHP_PTR_ADDR_MSB:0]};
            end else if (data_acc && ptr_r[`IOHP_PTR_AUTO_BIT]) begin
                ptr_r[`IOHP_PTR_ADDR_MSB:0] <= ptr_r[`IOHP_PTR_ADDR_MSB:0] + `IOHP_WORD_STEP;
            end
            // bid: length write judges the bid
            if (wr_start && sa_s1_r[3:0] == `IOHP_OFS_TX_LEN) begin
                bid_err_r <= bid_len_bad_in;
                waiting_r <= !bid_len_bad_in && !tx_space_in;
            end else if (waiting_r && tx_space_in) begin
                waiting_r   <= 1'b0;
                rdy_event_r <= 1'b1;
            end
            if (rx_valid_in && !rx_frame_r) begin
                rx_frame_r <= 1'b1;
                rx_phase_r <= `IOHP_RX_STATUS;
            end
            if (rd_start) begin
                rd_act_r <= 1'b1;
                case (sa_s1_r[3:0])
                    `IOHP_OFS_FRAME_LO, `IOHP_OFS_FRAME_HI: begin
                        case (rx_phase_r)
                            `IOHP_RX_STATUS: begin
                                sd_out     <= rx_status_in;
                                rx_phase_r <= `IOHP_RX_LENGTH;
                            end
                            `IOHP_RX_LENGTH: begin
                                sd_out     <= rx_length_in;
                                rx_phase_r <= `IOHP_RX_FRAME;
                            end
                            default: begin
                                sd_out <= rx_ext[15:0];
                                if (!rx_valid_in) begin
                                    rx_frame_r <= 1'b0;
                                end
                            end
                        endcase
                    end
                    `IOHP_OFS_QUEUE: begin
                        // pending ready event reports ahead of the external queue
                        if (rdy_event_r && rdy_ie_in) begin
                            sd_out      <= ready_report_word;
                            if (!(waiting_r && tx_space_in)) begin
                                rdy_event_r <= 1'b0;                    // set wins over clear
                            end
                        end else if (queue_valid_in) begin
                            sd_out        <= queue_head_in;
                            queue_pop_out <= 1'b1;
                        end else begin
                            sd_out <= `IOHP_QUEUE_EMPTY;
                        end
                    end
                    `IOHP_OFS_POINTER: begin
                        sd_out <= ptr_rd;
                    end
                    `IOHP_OFS_DATA_LO, `IOHP_OFS_DATA_HI: begin
                        if (ptr_r[`IOHP_PTR_ADDR_MSB:0] == `IOHP_ADDR_BUS_STATUS && is_data_lo) begin
                            sd_out <= bus_status_word;
                        end else begin
                            sd_out <= reg_rdata_in;
                        end
                    end
                    default: begin
                        sd_out <= 16'h0000;
                    end
                endcase
            end
        end
    end
endmodule
